/* hdl/dec_skip_defs.vh */
// Purpose: constants for the decrement-and-skip execution unit
// Assumes: 16-bit instruction words, 8-bit data path
// Notes:   included by dec_skip_exec.v
`ifndef DEC_SKIP_DEFS_VH
`define DEC_SKIP_DEFS_VH
// ------------------------------------------------------------
// Opcode fields
// ------------------------------------------------------------
`define OPC_HI            15
`define OPC_LO            10
`define OPC_DEC_SKIP_Z    6'h0B
`define OPC_DEC_SKIP_NZ   6'h13
`define BIT_DEST          9
`define BIT_BANK          8
// ------------------------------------------------------------
// Two-word first-word prefixes (upper nibble / upper 7 or 8 bits)
// ------------------------------------------------------------
`define TW_MOVE_HI        4'hC
`define TW_JUMP_HI        8'hEF
`define TW_CALL_HI        7'h76
`define TW_LOAD_PTR_HI    8'hEE
`define TW_MOVE_SP_HI     8'hEB
// ------------------------------------------------------------
// Addressing
// ------------------------------------------------------------
`define INDEXED_LIMIT     8'h5F
`define ACCESS_SPLIT      8'h60
`define SFR_BANK          4'hF
`define RESET_BYTE        8'h00
`endif

/* hdl/dec_skip_exec.v */
// Purpose: executes the two decrement-and-skip instructions on a Q1..Q4 core
// Assumes: q1..q4 are one-cycle phase enables from the core sequencer
// Notes:   file data is read through rd_addr/rd_data, written in Q4
//
// Contract
// - The file register is decremented by one; d=0 writes W, d=1 writes the file back.
// - Skip-if-zero skips the next instruction only when the result is zero.
// - Skip-if-nonzero skips the next instruction only when the result is not zero.
// - A skip discards the fetched next word and runs one no-op cycle, two cycles total.
// - If the discarded instruction is two-word, the instruction takes three cycles.
// - Each extra skip cycle does nothing in any of its four phases.
// - Extended set with a=0 and f at or below 95 uses indexed literal-offset addressing.
// - a=0 addresses the access bank, a=1 uses the bank pointer to pick the bank.
// - Neither instruction changes any arithmetic status flag.
`timescale 1ns/1ps
`include "dec_skip_defs.vh"

module dec_skip_exec (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        q1,
  input  wire        q2,
  input  wire        q4,
  input  wire        instr_valid,
  input  wire [15:0] instr,
  input  wire [15:0] next_instr,
  input  wire        ext_set_en,
  input  wire [3:0]  bank_pointer,
  input  wire [7:0]  index_base,
  input  wire [7:0]  rd_data,
  output reg  [11:0] rd_addr,
  output reg         wr_en,
  output reg  [11:0] wr_addr,
  output reg  [7:0]  wr_data,
  output reg         w_wr_en,
  output reg  [7:0]  w_wr_data,
  output reg         flush,
  output reg         nop_cycle,
  output reg         busy,
  output reg         status_wr_en
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [2:0] ST_EXEC = 3'b001;
  localparam [2:0] ST_NOP1 = 3'b010;
  localparam [2:0] ST_NOP2 = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         active_q;
  reg         is_nz_q;
  reg         dest_q;
  reg  [11:0] addr_q;
  reg  [7:0]  res_q;
  reg         two_word_q;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire [5:0] opc      = instr[`OPC_HI:`OPC_LO];
  wire       hit_z    = (opc == `OPC_DEC_SKIP_Z);
  wire       hit_nz   = (opc == `OPC_DEC_SKIP_NZ);
  wire       hit      = instr_valid & (hit_z | hit_nz);
  wire       a_bit    = instr[`BIT_BANK];
  wire [7:0] f_addr   = instr[7:0];

  wire       tw_move;
  wire       tw_jump;
  wire       tw_call;
  wire       tw_load_ptr;
  wire       tw_move_sp;

  prefix_match #(
    .WIDTH  (4),
    .PREFIX (`TW_MOVE_HI)
  ) u_tw_move (
    .word  (next_instr),
    .match (tw_move)
  );

  prefix_match #(
    .WIDTH  (8),
    .PREFIX (`TW_JUMP_HI)
  ) u_tw_jump (
    .word  (next_instr),
    .match (tw_jump)
  );

  prefix_match #(
    .WIDTH  (7),
    .PREFIX (`TW_CALL_HI)
  ) u_tw_call (
    .word  (next_instr),
    .match (tw_call)
  );

  prefix_match #(
    .WIDTH  (8),
    .PREFIX (`TW_LOAD_PTR_HI)
  ) u_tw_load_ptr (
    .word  (next_instr),
    .match (tw_load_ptr)
  );

  prefix_match #(
    .WIDTH  (8),
    .PREFIX (`TW_MOVE_SP_HI)
  ) u_tw_move_sp (
    .word  (next_instr),
    .match (tw_move_sp)
  );

  wire       next_two = tw_move |
                        tw_jump |
                        tw_call |
                        tw_load_ptr |
                        tw_move_sp;

  reg [11:0] eff_addr;
  always @* begin
    if (a_bit) begin
      eff_addr = {bank_pointer, f_addr};
    end else if (ext_set_en && (f_addr <= `INDEXED_LIMIT)) begin
      eff_addr = {4'h0, index_base + f_addr};
    end else if (f_addr < `ACCESS_SPLIT) begin
      eff_addr = {4'h0, f_addr};
    end else begin
      eff_addr = {`SFR_BANK, f_addr};
    end
  end

  wire [7:0] dec_val = rd_data - 8'h01;
  wire       is_zero = (res_q == `RESET_BYTE);
  wire       do_skip = is_nz_q ? ~is_zero : is_zero;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (q4 && active_q && do_skip) begin
          state_d = ST_NOP1;
        end
      end
      ST_NOP1: begin
        if (q4) begin
          state_d = two_word_q ? ST_NOP2 : ST_EXEC;
        end
      end
      ST_NOP2: begin
        if (q4) begin
          state_d = ST_EXEC;
        end
      end
      default: state_d = ST_EXEC;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_q      <= ST_EXEC;
      active_q     <= 1'b0;
      is_nz_q      <= 1'b0;
      dest_q       <= 1'b0;
      addr_q       <= 12'h000;
      res_q        <= `RESET_BYTE;
      two_word_q   <= 1'b0;
      rd_addr      <= 12'h000;
      wr_en        <= 1'b0;
      wr_addr      <= 12'h000;
      wr_data      <= `RESET_BYTE;
      w_wr_en      <= 1'b0;
      w_wr_data    <= `RESET_BYTE;
      flush        <= 1'b0;
      nop_cycle    <= 1'b0;
      busy         <= 1'b0;
      status_wr_en <= 1'b0;
    end else begin
      state_q      <= state_d;
      wr_en        <= 1'b0;
      w_wr_en      <= 1'b0;
      flush        <= 1'b0;
      status_wr_en <= 1'b0;
      if (state_q == ST_EXEC) begin
        if (q1 && hit) begin
          active_q   <= 1'b1;
          is_nz_q    <= hit_nz;
          dest_q     <= instr[`BIT_DEST];
          addr_q     <= eff_addr;
          rd_addr    <= eff_addr;
          two_word_q <= next_two;
          busy       <= 1'b1;
        end
        if (q2 && active_q) begin
          res_q <= dec_val;
        end
        if (q4 && active_q) begin
          active_q <= 1'b0;
          if (dest_q) begin
            wr_en   <= 1'b1;
            wr_addr <= addr_q;
            wr_data <= res_q;
          end else begin
            w_wr_en   <= 1'b1;
            w_wr_data <= res_q;
          end
          flush     <= do_skip;
          nop_cycle <= do_skip;
          busy      <= do_skip;
        end
      end else if (q4) begin
        nop_cycle <= (state_d != ST_EXEC);
        busy      <= (state_d != ST_EXEC);
      end
    end
  end

endmodule

// ------------------------------------------------------------
// Upper-bit prefix compare
// ------------------------------------------------------------
module prefix_match #(
  parameter integer     WIDTH  = 4,
  parameter [WIDTH-1:0] PREFIX = {WIDTH{1'b0}}
) (
  input  wire [15:0] word,
  output wire        match
);

  assign match = (word[15:16-WIDTH] == PREFIX);

endmodule

/* dv/dec_skip_props.sv */
// Purpose: port assertions for dec_skip_exec
// Assumes: one clock, rst_n sync active low
// Notes:   bound after the module
`timescale 1ns/1ps
module dec_skip_props (
  input wire        clk,
  input wire        rst_n,
  input wire        q1,
  input wire        q4,
  input wire        instr_valid,
  input wire        busy,
  input wire        wr_en,
  input wire        w_wr_en,
  input wire        flush,
  input wire        nop_cycle,
  input wire        status_wr_en,
  input wire [15:0] instr,
  input wire [3:0]  bank_pointer,
  input wire [11:0] rd_addr,
  input wire [7:0]  wr_data,
  input wire [7:0]  w_wr_data
);
  reg  [5:0] op_q;
  wire [7:0] res = wr_en ? wr_data : w_wr_data;
  wire       wr  = wr_en | w_wr_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Opcode of the instruction in flight
  always @(posedge clk) if (q1 && instr_valid && !busy) op_q <= instr[15:10];
  property p_stat; !status_wr_en; endproperty
  a_stat: assert property (p_stat) else $error("status write");
  property p_dest; !(wr_en && w_wr_en); endproperty
  a_dest: assert property (p_dest) else $error("two targets");
  property p_wr_q4; wr |-> $past(q4); endproperty
  a_wr_q4: assert property (p_wr_q4) else $error("write off q4");
  property p_flush; flush |-> wr && nop_cycle; endproperty
  a_flush: assert property (p_flush) else $error("flush alone");
  property p_quiet; nop_cycle && !flush |-> !wr; endproperty
  a_quiet: assert property (p_quiet) else $error("nop writes");
  property p_zero; wr && op_q == 6'h0B |-> flush == (res == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero skip");
  property p_nz; wr && op_q == 6'h13 |-> flush == (res != 8'h00); endproperty
  a_nz: assert property (p_nz) else $error("nonzero skip");
  property p_bank;
    $rose(busy) && $past(instr[8]) |-> rd_addr == {$past(bank_pointer), $past(instr[7:0])};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address");
endmodule
bind dec_skip_exec dec_skip_props chk (
  .clk          (clk),
  .rst_n        (rst_n),
  .q1           (q1),
  .q4           (q4),
  .instr_valid  (instr_valid),
  .busy         (busy),
  .wr_en        (wr_en),
  .w_wr_en      (w_wr_en),
  .flush        (flush),
  .nop_cycle    (nop_cycle),
  .status_wr_en (status_wr_en),
  .instr        (instr),
  .bank_pointer (bank_pointer),
  .rd_addr      (rd_addr),
  .wr_data      (wr_data),
  .w_wr_data    (w_wr_data)
);

/* dv/testbench.sv */
// Purpose: directed bench for dec_skip_exec
// Assumes: bench makes q phases, inputs change on falling edge
// Notes:   busy spans 4 cycles per instruction cycle less one
`timescale 1ns/1ps
module testbench;
  reg         clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
  reg  [1:0]  ph = 2'h0;
  reg  [15:0] instr = 16'h0000, next_instr = 16'h0000;
  reg  [3:0]  bank_pointer = 4'h0;
  reg  [7:0]  index_base = 8'h00, rd_data = 8'h00;
  wire [11:0] rd_addr, wr_addr;
  wire [7:0]  wr_data, w_wr_data;
  wire        wr_en, w_wr_en, flush, nop_cycle, busy, status_wr_en;
  integer     failures = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  always @(negedge clk) ph <= ph + 2'h1;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      failures = failures + 1;
      summarize;
    end
  end
  dec_skip_exec uut (
    .clk          (clk),
    .rst_n        (rst_n),
    .q1           (ph == 2'h0),
    .q2           (ph == 2'h1),
    .q4           (ph == 2'h3),
    .instr_valid  (instr_valid),
    .instr        (instr),
    .next_instr   (next_instr),
    .ext_set_en   (ext_set_en),
    .bank_pointer (bank_pointer),
    .index_base   (index_base),
    .rd_data      (rd_data),
    .rd_addr      (rd_addr),
    .wr_en        (wr_en),
    .wr_addr      (wr_addr),
    .wr_data      (wr_data),
    .w_wr_en      (w_wr_en),
    .w_wr_data    (w_wr_data),
    .flush        (flush),
    .nop_cycle    (nop_cycle),
    .busy         (busy),
    .status_wr_en (status_wr_en)
  );
  task summarize;
    begin
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Runs one instruction and judges writes, skip, length and address
  task exec(input [15:0] i, n, input [7:0] v, input [11:0] a, input tw);
    reg [7:0] r, d;
    reg [11:0] wa;
    reg hit, skip, dst;
    integer k, nb, nw, nf, nn, ns;
    begin
      r = v - 8'h01;
      hit = i[15:10] == 6'h0B || i[15:10] == 6'h13;
      skip = hit && ((r == 8'h00) == (i[15:10] == 6'h0B));
      nb = 0;
      nw = 0;
      nf = 0;
      nn = 0;
      ns = 0;
      d = 8'h00;
      dst = 1'b0;
      wa = 12'h000;
      while (ph != 2'h3) @(negedge clk);
      instr = i;
      next_instr = n;
      rd_data = v;
      instr_valid = 1'b1;
      for (k = 0; k < 14; k = k + 1) begin
        @(negedge clk);
        instr_valid = 1'b0;
        if (k == 1 && hit) chk(rd_addr, a);
        nb = nb + busy;
        nf = nf + flush;
        nn = nn + nop_cycle;
        ns = ns + status_wr_en;
        if (wr_en | w_wr_en) begin
          nw = nw + 1;
          dst = wr_en;
          d = wr_en ? wr_data : w_wr_data;
          if (wr_en) wa = wr_addr;
        end
      end
      chk(nw, hit);
      chk(d, hit ? r : 8'h00);
      chk(dst, hit & i[9]);
      chk(wa, (hit & i[9]) ? a : 12'h000);
      chk(nf, skip);
      chk(nb, hit ? 4 * (1 + skip * (1 + tw)) - 1 : 0);
      chk(nn, 4 * skip * (1 + tw));
      chk(ns, 0);
    end
  endtask
  task t_plain;
    begin
      bank_pointer = 4'h3;
      exec(16'h2F05, 16'h0000, 8'h05, 12'h305, 1'b0);
      exec(16'h0420, 16'h0000, 8'h03, 12'h000, 1'b0);
      $display("t_plain done");
    end
  endtask
  task t_skip;
    begin
      exec(16'h2C20, 16'h0000, 8'h01, 12'h020, 1'b0);
      exec(16'h2E40, 16'hEF12, 8'h01, 12'h040, 1'b1);
      exec(16'h2E40, 16'hEC00, 8'h01, 12'h040, 1'b1);
      $display("t_skip done");
    end
  endtask
  task t_nonzero;
    begin
      exec(16'h4F07, 16'h0000, 8'h01, 12'h307, 1'b0);
      exec(16'h4C90, 16'hC000, 8'h00, 12'hF90, 1'b1);
      $display("t_nonzero done");
    end
  endtask
  task t_ext;
    begin
      ext_set_en = 1'b1;
      index_base = 8'h10;
      exec(16'h2C5F, 16'h0000, 8'h03, 12'h06F, 1'b0);
      exec(16'h2C60, 16'h0000, 8'h03, 12'hF60, 1'b0);
      ext_set_en = 1'b0;
      $display("t_ext done");
    end
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    t_plain;
    t_skip;
    t_nonzero;
    t_ext;
    summarize;
  end
endmodule
